// [verilog/clk_gate_pkg.sv]
// peripheral clock gating: offsets, field positions, reset values, carriers
// assumes a 32-bit apb slave with word-aligned registers
package clk_gate_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] ENABLE0_OFFSET = 12'h008;
   localparam logic [11:0] ENABLE1_OFFSET = 12'h00C;
   localparam logic [31:0] ENABLE0_RESET = 32'h0000_0001;
   localparam logic [31:0] ENABLE1_RESET = 32'h0000_0000;
   // implemented bits; everything else is reserved
   localparam logic [31:0] ENABLE0_MASK = 32'h0001_73FF;
   localparam logic [31:0] ENABLE1_MASK = 32'h0203_1001;

   // ----------------------------------------------------------------
   // field positions, first enable register
   // ----------------------------------------------------------------
   localparam int SERIAL0_BIT = 16;
   localparam int SPI_PORT2_BIT = 14;
   localparam int SPI_PORT1_BIT = 13;
   localparam int SPI_PORT0_BIT = 12;
   localparam int TWOWIRE1_BIT = 9;
   localparam int TWOWIRE0_BIT = 8;
   localparam int COMPARATOR_PAIR_BIT = 7;
   localparam int CLOCK_OUTPUT_BIT = 6;
   localparam int TIMER3_BIT = 5;
   localparam int TIMER0_BIT = 2;
   localparam int RTC_BUS_BIT = 1;
   localparam int WATCHDOG_BIT = 0;

   // ----------------------------------------------------------------
   // field positions, second enable register
   // ----------------------------------------------------------------
   localparam int TOUCH_KEY_BIT = 25;
   localparam int PULSE_UNIT1_BIT = 17;
   localparam int PULSE_UNIT0_BIT = 16;
   localparam int DAC_BIT = 12;
   localparam int SMARTCARD0_BIT = 0;

   // ----------------------------------------------------------------
   // bus carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic hit;
   } bus_rsp_t;
endpackage

// [verilog/clock_gate_cell.sv]
// one glitch-free clock gate
// assumes clk is the source clock and en comes from clk's domain
`timescale 1ns/1ps
`default_nettype none
module clock_gate_cell (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic en,
   // gated clock
   output logic gclk
);
   logic en_low;
   logic next_en_low;

   // ----------------------------------------------------------------
   // enable capture while clk is low
   // ----------------------------------------------------------------
   // next value of the held enable
   always_comb begin
      next_en_low = en;
   end

   // captured on the falling edge so the and gate sees no enable change
   // during the high phase; only rst_n falling in the high phase can cut a pulse short
   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_low <= 1'b0;
      end else begin
         en_low <= next_en_low;
      end
   end

   // gated output follows the source only while enabled
   assign gclk = clk & en_low;
endmodule // clock_gate_cell
`default_nettype wire

// [verilog/apb_reg_port.sv]
// apb slave front end with one wait state
// assumes a well-behaved apb master on pclk
`timescale 1ns/1ps
`default_nettype none
module apb_reg_port
   import clk_gate_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // register file side
   output clk_gate_pkg::bus_req_t req,
   output logic wr_commit,
   input wire clk_gate_pkg::bus_rsp_t rsp
);
   import clk_gate_pkg::*;

   logic next_pready;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic access;

   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   assign access = psel & penable;
   assign req = '{write: pwrite, addr: paddr, wdata: pwdata};
   // write lands on the same edge that the master samples pready
   assign wr_commit = access & pready & pwrite;

   // answer one cycle into the access phase
   always_comb begin
      next_pready = access & ~pready;
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (access && !pready) begin
         next_prdata = (!pwrite && rsp.hit) ? rsp.rdata : 32'h0000_0000;
         next_pslverr = ~rsp.hit; // unmapped address
      end
   end

   // response registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end
endmodule // apb_reg_port
`default_nettype wire

// [verilog/apb_peripheral_clock_gating.sv]
// peripheral clock gating: two enable registers over apb, one gate per implemented bit
// assumes all peripheral clocks derive from pclk and that register_lock_open
// comes from logic on pclk
//
// Operation
// - bit 16 gates serial port 0 clock
// - bits 14..12 gate spi ports 2..0
// - bits 9..8 gate two-wire ports 1..0
// - bit 7 gates shared comparator pair clock
// - bit 6 gates clock output divider clock
// - bits 5..2 gate timers 3..0
// - bit 1 gates rtc bus clock only
// - bit 0 gates watchdog, writable when unlocked
// - second register at 0x0C, resets all zero
// - second register bit 25 gates touch key
// - bits 17..16 gate pulse units 1..0
// - bit 12 gates dac clock
// - bit 0 gates smart card 0
// - first register at 0x08, resets to 0x1
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module apb_peripheral_clock_gating
   import clk_gate_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // protected register lock, high while open
   input wire logic register_lock_open,
   // gated clocks, one per register bit; reserved bits stay low
   output logic [31:0] gated_clk0,
   output logic [31:0] gated_clk1,
   // individual peripheral clocks
   output logic serial0_clk_gate,
   output logic spi_port2_clk_gate,
   output logic spi_port1_clk_gate,
   output logic spi_port0_clk_gate,
   output logic twowire1_clk_gate,
   output logic twowire0_clk_gate,
   output logic comparator_pair_clk_gate,
   output logic clock_output_clk_gate,
   output logic [3:0] timer_clk_gate,
   output logic rtc_bus_clk_gate,
   output logic watchdog_clk_gate,
   output logic touch_key_clk_gate,
   output logic pulse_unit1_clk_gate,
   output logic pulse_unit0_clk_gate,
   output logic dac_clk_gate,
   output logic smartcard0_clk_gate
);
   import clk_gate_pkg::*;

   bus_req_t req;
   bus_rsp_t rsp;
   logic wr_commit;
   logic [31:0] apb_clock_enable_0;
   logic [31:0] apb_clock_enable_1;
   logic [31:0] next_enable_0;
   logic [31:0] next_enable_1;
   logic [31:0] write_mask_0;

   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   apb_reg_port u_port (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .req(req),
      .wr_commit(wr_commit),
      .rsp(rsp)
   );

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   // reserved bits are never stored, so they read back as zero
   always_comb begin
      rsp = '{rdata: 32'h0000_0000, hit: 1'b0};
      case (req.addr)
         ENABLE0_OFFSET: begin
            rsp = '{rdata: apb_clock_enable_0, hit: 1'b1};
         end
         ENABLE1_OFFSET: begin
            rsp = '{rdata: apb_clock_enable_1, hit: 1'b1};
         end
         default: begin
            rsp = '{rdata: 32'h0000_0000, hit: 1'b0};
         end
      endcase
   end

   // ----------------------------------------------------------------
   // enable registers
   // ----------------------------------------------------------------
   // watchdog bit drops out of the mask while the lock is closed
   always_comb begin
      write_mask_0 = ENABLE0_MASK;
      write_mask_0[WATCHDOG_BIT] = register_lock_open;
   end

   // merge writes through the masks; reserved bits stay zero
   always_comb begin
      next_enable_0 = apb_clock_enable_0;
      next_enable_1 = apb_clock_enable_1;
      if (wr_commit && req.addr == ENABLE0_OFFSET) begin
         next_enable_0 = (apb_clock_enable_0 & ~write_mask_0)
                       | (req.wdata & write_mask_0);
      end
      if (wr_commit && req.addr == ENABLE1_OFFSET) begin
         next_enable_1 = req.wdata & ENABLE1_MASK;
      end
   end

   // watchdog clock alone runs out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_clock_enable_0 <= ENABLE0_RESET;
         apb_clock_enable_1 <= ENABLE1_RESET;
      end else begin
         apb_clock_enable_0 <= next_enable_0;
         apb_clock_enable_1 <= next_enable_1;
      end
   end

   // ----------------------------------------------------------------
   // clock gates
   // ----------------------------------------------------------------
   // one gate per implemented bit; a gated clock cannot come from a
   // flip-flop, so these outputs are the gate's and-term
   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_gate
         if (ENABLE0_MASK[i]) begin : g_reg0
            clock_gate_cell u_gate0 (
               .clk(pclk),
               .rst_n(presetn),
               .en(apb_clock_enable_0[i]),
               .gclk(gated_clk0[i])
            );
         end else begin : g_idle0
            assign gated_clk0[i] = 1'b0;
         end
         if (ENABLE1_MASK[i]) begin : g_reg1
            clock_gate_cell u_gate1 (
               .clk(pclk),
               .rst_n(presetn),
               .en(apb_clock_enable_1[i]),
               .gclk(gated_clk1[i])
            );
         end else begin : g_idle1
            assign gated_clk1[i] = 1'b0;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // named peripheral clocks
   // ----------------------------------------------------------------
   assign serial0_clk_gate = gated_clk0[SERIAL0_BIT];
   assign spi_port2_clk_gate = gated_clk0[SPI_PORT2_BIT];
   assign spi_port1_clk_gate = gated_clk0[SPI_PORT1_BIT];
   assign spi_port0_clk_gate = gated_clk0[SPI_PORT0_BIT];
   assign twowire1_clk_gate = gated_clk0[TWOWIRE1_BIT];
   assign twowire0_clk_gate = gated_clk0[TWOWIRE0_BIT];
   // one clock feeds both comparators
   assign comparator_pair_clk_gate = gated_clk0[COMPARATOR_PAIR_BIT];
   assign clock_output_clk_gate = gated_clk0[CLOCK_OUTPUT_BIT];
   // timer n sits at bit n+2
   assign timer_clk_gate = gated_clk0[TIMER3_BIT:TIMER0_BIT];
   // bus side only; the rtc counting clock is selected elsewhere
   assign rtc_bus_clk_gate = gated_clk0[RTC_BUS_BIT];
   assign watchdog_clk_gate = gated_clk0[WATCHDOG_BIT];
   assign touch_key_clk_gate = gated_clk1[TOUCH_KEY_BIT];
   assign pulse_unit1_clk_gate = gated_clk1[PULSE_UNIT1_BIT];
   assign pulse_unit0_clk_gate = gated_clk1[PULSE_UNIT0_BIT];
   assign dac_clk_gate = gated_clk1[DAC_BIT];
   assign smartcard0_clk_gate = gated_clk1[SMARTCARD0_BIT];
endmodule // apb_peripheral_clock_gating
`default_nettype wire

// [tb/clk_gate_checker_assertions.sv]
// checker for the peripheral clock gate block: apb answers and gated clocks
// assumes a bind to apb_peripheral_clock_gating, gates built from pclk
`timescale 1ns/1ps
`default_nettype none
module clk_gate_checker
   import clk_gate_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // lock and gated clocks
   input wire logic register_lock_open,
   input wire logic [31:0] gated_clk0,
   input wire logic [31:0] gated_clk1
);
   import clk_gate_pkg::*;
   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   default disable iff (!presetn);
   logic hit;
   logic wr0;
   logic wr1;
   // decode as seen by the master, for commit and refusal checks
   assign hit = (paddr == ENABLE0_OFFSET) || (paddr == ENABLE1_OFFSET);
   assign wr0 = pready && pwrite && paddr == ENABLE0_OFFSET;
   assign wr1 = pready && pwrite && paddr == ENABLE1_OFFSET;
   chk_one_wait: assert property (@(posedge pclk)
      psel && $rose(penable) |-> !pready ##1 pready)
      else $error("ready not after one wait state");
   chk_ready_pulse: assert property (@(posedge pclk)
      pready |-> psel && penable ##1 !pready)
      else $error("ready outside access or too long");
   chk_err_map: assert property (@(posedge pclk)
      pslverr == (pready && !hit))
      else $error("error flag does not match decode");
   chk_rdata_idle: assert property (@(posedge pclk)
      !pready || pwrite |-> prdata == '0)
      else $error("read data not zero outside reads");
   // gates sampled at the falling edge, while pclk is still high
   chk_read_back: assert property (@(negedge pclk)
      pready && !pwrite |-> prdata == (paddr == ENABLE0_OFFSET ?
      gated_clk0 : paddr == ENABLE1_OFFSET ? gated_clk1 : 32'h0))
      else $error("read data differs from running gates");
   chk_write_first: assert property (@(negedge pclk)
      wr0 |-> ##2 ((gated_clk0 ^ $past(pwdata, 2)) & ENABLE0_MASK &
      32'hFFFF_FFFE) == 32'h0)
      else $error("first register gates miss the write");
   chk_wdog_lock: assert property (@(negedge pclk)
      wr0 && !register_lock_open |-> ##2
      gated_clk0[0] == $past(gated_clk0[0], 2))
      else $error("watchdog gate written while locked");
   chk_wdog_open: assert property (@(negedge pclk)
      wr0 && register_lock_open |-> ##2 gated_clk0[0] == $past(pwdata[0], 2))
      else $error("watchdog gate missed an unlocked write");
   chk_write_second: assert property (@(negedge pclk)
      wr1 |-> ##2 gated_clk1 == ($past(pwdata, 2) & ENABLE1_MASK))
      else $error("second register gates miss the write");
   chk_reserved_low: assert property (@(negedge pclk)
      (gated_clk0 & ~ENABLE0_MASK) == 32'h0 &&
      (gated_clk1 & ~ENABLE1_MASK) == 32'h0)
      else $error("reserved gate running");
   chk_low_phase: assert property (@(posedge pclk)
      gated_clk0 == 32'h0 && gated_clk1 == 32'h0)
      else $error("gated clock high while pclk low");
   cov_write0: cover property (@(posedge pclk) wr0);
   cov_read: cover property (@(posedge pclk) pready && !pwrite && hit);
   cov_refused: cover property (@(posedge pclk) pslverr);
endmodule // clk_gate_checker
bind apb_peripheral_clock_gating clk_gate_checker u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .register_lock_open(register_lock_open),
   .gated_clk0(gated_clk0), .gated_clk1(gated_clk1));
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the peripheral clock gate block over apb
// assumes one pclk domain and the package offsets and masks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import clk_gate_pkg::*;
   `define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
      bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
   // -------------------------------------------------------------
   // signals, rows and design
   // -------------------------------------------------------------
   typedef struct packed {
      logic w;
      logic lock;
      logic [11:0] a;
      logic [31:0] d;
   } row_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic register_lock_open = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, gated_clk0, gated_clk1, m0, m1, rd;
   logic pready, pslverr, ser, sp2, sp1, sp0, tw1, tw0, cmp, cko, rtc, wdg;
   logic tk, pu1, pu0, dac, sc0;
   logic [3:0] tmr;
   int bad_count = 0, tests_run = 0;
   // plain cases: read, write, lock, reserved and unmapped places
   row_t rows[15] = '{'{1'b0, 1'b0, 12'h008, 32'h0},
      '{1'b0, 1'b0, 12'h00C, 32'h0}, '{1'b1, 1'b0, 12'h008, 32'hFFFF_FFFF},
      '{1'b1, 1'b0, 12'h008, 32'h0}, '{1'b1, 1'b1, 12'h008, 32'h0},
      '{1'b1, 1'b0, 12'h008, 32'h0001_0001},
      '{1'b1, 1'b1, 12'h008, 32'h5555_5555},
      '{1'b1, 1'b1, 12'h008, 32'hAAAA_AAAA},
      '{1'b1, 1'b1, 12'h00C, 32'hFFFF_FFFF},
      '{1'b1, 1'b1, 12'h00C, 32'h5555_5555},
      '{1'b1, 1'b1, 12'h00C, 32'hAAAA_AAAA},
      '{1'b1, 1'b1, 12'h010, 32'hFFFF_FFFF}, '{1'b0, 1'b1, 12'h004, 32'h0},
      '{1'b0, 1'b1, 12'h008, 32'h0}, '{1'b0, 1'b1, 12'h00C, 32'h0}};
   apb_peripheral_clock_gating i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .register_lock_open(register_lock_open), .gated_clk0(gated_clk0),
      .gated_clk1(gated_clk1), .serial0_clk_gate(ser),
      .spi_port2_clk_gate(sp2), .spi_port1_clk_gate(sp1),
      .spi_port0_clk_gate(sp0), .twowire1_clk_gate(tw1),
      .twowire0_clk_gate(tw0), .comparator_pair_clk_gate(cmp),
      .clock_output_clk_gate(cko), .timer_clk_gate(tmr),
      .rtc_bus_clk_gate(rtc), .watchdog_clk_gate(wdg),
      .touch_key_clk_gate(tk), .pulse_unit1_clk_gate(pu1),
      .pulse_unit0_clk_gate(pu0), .dac_clk_gate(dac),
      .smartcard0_clk_gate(sc0));
   always #10 pclk = ~pclk;
   task automatic wrap_up;
      if (bad_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one transfer from just after an edge; hold keeps psel for back to back
   task automatic apb(input row_t r, input logic hold);
      int n;
      psel <= 1'b1;
      pwrite <= r.w;
      paddr <= r.a;
      pwdata <= r.d;
      register_lock_open <= r.lock;
      @(posedge pclk) penable <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         bad_count++;
         wrap_up();
      end
      rd = r.w ? 32'h0 : r.a == 12'h008 ? m0 : r.a == 12'h00C ? m1 : 32'h0;
      `CHK("prdata", rd, prdata)
      `CHK("pslverr", r.a != 12'h008 && r.a != 12'h00C, pslverr)
      @(posedge pclk) penable <= 1'b0;
      if (!hold) psel <= 1'b0;
      if (!r.lock) r.d[0] = m0[0];
      if (r.w && r.a == 12'h008) m0 = r.d & ENABLE0_MASK;
      if (r.w && r.a == 12'h00C) m1 = r.d & ENABLE1_MASK;
   endtask
   // gates seen in the high and then the low phase of the next cycle
   task automatic gates;
      @(posedge pclk);
      #5;
      `CHK("gated_clk0", m0, gated_clk0)
      `CHK("gated_clk1", m1, gated_clk1)
      `CHK("named0", {m0[16], m0[14:12], m0[9:0]}, {ser, sp2, sp1, sp0, tw1,
         tw0, cmp, cko, tmr, rtc, wdg})
      `CHK("named1", {m1[25], m1[17:16], m1[12], m1[0]}, {tk, pu1, pu0,
         dac, sc0})
      #10;
      `CHK("low phase", 64'h0, {gated_clk0, gated_clk1})
      @(posedge pclk);
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      m0 = ENABLE0_RESET;
      m1 = ENABLE1_RESET;
      foreach (rows[i]) begin
         apb(rows[i], 1'b0);
         gates();
      end
      // back to back write then read, no idle cycle between
      apb('{1'b1, 1'b1, 12'h00C, 32'h0200_0001}, 1'b1);
      apb('{1'b0, 1'b1, 12'h00C, 32'h0}, 1'b0);
      // reset in mid-run stops every gate, then reset values return
      @(posedge pclk) presetn <= 1'b0;
      #5;
      `CHK("in reset", 64'h0, {gated_clk0, gated_clk1})
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      m0 = ENABLE0_RESET;
      m1 = ENABLE1_RESET;
      apb('{1'b0, 1'b0, 12'h008, 32'h0}, 1'b0);
      apb('{1'b0, 1'b0, 12'h00C, 32'h0}, 1'b0);
      gates();
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
